// ---- hw/sadc_ctrl.sv ----
// Control logic of a three-wire serial sampling converter with nap and sleep.
//
// Function
// - Interface is serial clock and sample strobe in, one serial result out.
// - Result is natural binary over 16384 or 4096 steps.
// - Difference above full span gives all ones, below zero all zeros.
// - After power-up the converter is active, no setup needed.
// - Two strobe rises with no serial clock rise between enter nap.
// - Nap keeps the reference powered; a clock rise wakes it at once.
// - Four strobe rises with no serial clock rise among them enter sleep.
// - A clock rise wakes from sleep; reference then settles for 2 ms.
// - A strobe rise starts a frame; more rises ignored for 16 clock rises.
// - Whole result leaves within the first 16 clock periods of a frame.
// - Strobe of any duty cycle is accepted, usable as frame sync.
// - Each clock rise advances; bits leave MSB first from the third rise.
// - Result output is high impedance whenever no bit is being sent.
// - Each word holds the sample taken at the previous frame start.
`timescale 1ns/1ps
`default_nettype none

module sadc_ctrl #(
    parameter int RES           = sadc_pkg::RES_WIDE,
    parameter int SETTLE_CYCLES = sadc_pkg::REF_SETTLE_CYCLES
) (
    // System clock and reset.
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Serial link pins.
    input  wire logic                  serial_clk,
    input  wire logic                  sample_strobe,
    output logic                       serial_result_out,
    output logic                       serial_result_oe,
    // Digitised input difference, in steps, held steady around each strobe.
    input  wire logic signed [RES+1:0] sample_diff,
    // Power status.
    output logic                       nap_mode,
    output logic                       sleep_mode,
    output logic                       ref_powered,
    output logic                       ref_settled
);

    localparam int         SW       = $clog2(SETTLE_CYCLES + 1);
    localparam logic [4:0] SEQ_LAST = 5'(RES + int'(sadc_pkg::SEQ_FIRST) - 1);
    localparam logic [4:0] SEQ_OPEN = sadc_pkg::SEQ_FRAME + sadc_pkg::SEQ_FIRST - 5'h01;

    // ========================================================================
    // Link domain: frame sequencing and serial output
    // ========================================================================
    logic                    strb_l;
    logic                    strb_l_d_r;
    logic signed [RES+1:0]   diff_l;
    logic        [RES-1:0]   code_w;
    logic        [RES-1:0]   pend_r;
    logic        [RES-1:0]   shift_r;
    logic        [4:0]       seq_r;
    logic                    strb_rise_l;
    logic                    start_w;
    logic                    out_r;
    logic                    oe_r;

    // The strobe is a pin, so it is resynchronised even in the link domain.
    sadc_sync2 #(.W(1)) u_strb_l (
        .clk (serial_clk),
        .rst (rst),
        .d   (sample_strobe),
        .q   (strb_l)
    );

    // The input difference is a slow level; two stages keep metastability out.
    sadc_sync2 #(.W(RES + 2)) u_diff_l (
        .clk (serial_clk),
        .rst (rst),
        .d   (sample_diff),
        .q   (diff_l)
    );

    sadc_coder #(.RES(RES)) u_coder (
        .diff (diff_l),
        .code (code_w)
    );

    // Only the rising edge matters, so any strobe duty cycle works.
    always_ff @(posedge serial_clk or posedge rst) begin
        if (rst) begin
            strb_l_d_r <= 1'b0;
        end else begin
            strb_l_d_r <= strb_l;
        end
    end

    assign strb_rise_l = strb_l & ~strb_l_d_r;
    // Two sync stages put the start on the third rise, so the lock-out runs two counts longer.
    assign start_w     = strb_rise_l && (seq_r >= SEQ_OPEN);

    // Frame position; saturates so a stopped frame reads as idle.
    always_ff @(posedge serial_clk or posedge rst) begin
        if (rst) begin
            seq_r <= sadc_pkg::SEQ_IDLE;
        end else if (start_w) begin
            seq_r <= sadc_pkg::SEQ_FIRST;
        end else if (seq_r != sadc_pkg::SEQ_IDLE) begin
            seq_r <= seq_r + 5'h01;
        end
    end

    // Each start ships the word caught at the previous start and stores a new one.
    always_ff @(posedge serial_clk or posedge rst) begin
        if (rst) begin
            pend_r  <= '0;
            shift_r <= '0;
        end else if (start_w) begin
            pend_r  <= code_w;
            shift_r <= {pend_r[RES-2:0], 1'b0};
        end else if (oe_r) begin
            shift_r <= {shift_r[RES-2:0], 1'b0};
        end
    end

    // Output bit and enable change only on clock rises, valid by the next one.
    always_ff @(posedge serial_clk or posedge rst) begin
        if (rst) begin
            out_r <= 1'b0;
            oe_r  <= 1'b0;
        end else if (start_w) begin
            out_r <= pend_r[RES-1];
            oe_r  <= 1'b1;
        end else if (oe_r && (seq_r < SEQ_LAST)) begin
            out_r <= shift_r[RES-1];
            oe_r  <= 1'b1;
        end else begin
            out_r <= 1'b0;
            oe_r  <= 1'b0;
        end
    end

    assign serial_result_out = out_r;
    assign serial_result_oe  = oe_r;

    // ========================================================================
    // System domain: power-down detection
    // ========================================================================
    // The serial clock may be stopped while strobes are counted, so this part
    // watches both pins from the free-running system clock.
    logic                    strb_s;
    logic                    sck_s;
    logic                    strb_s_d_r;
    logic                    sck_s_d_r;
    logic                    strb_rise_s;
    logic                    sck_rise_s;
    logic        [2:0]       strobe_cnt_r;
    logic        [2:0]       strobe_cnt_nxt;
    sadc_pkg::sadc_pmode_e   pmode_r;
    sadc_pkg::sadc_pmode_e   pmode_nxt;
    logic        [SW-1:0]    settle_cnt_r;
    logic                    nap_r;
    logic                    sleep_r;
    logic                    ref_pwr_r;
    logic                    settled_r;

    sadc_sync2 #(.W(2)) u_pins_s (
        .clk (clk),
        .rst (rst),
        .d   ({sample_strobe, serial_clk}),
        .q   ({strb_s, sck_s})
    );

    // Edge detectors sit behind the synchroniser's second stage.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strb_s_d_r <= 1'b0;
            sck_s_d_r  <= 1'b0;
        end else begin
            strb_s_d_r <= strb_s;
            sck_s_d_r  <= sck_s;
        end
    end

    assign strb_rise_s = strb_s & ~strb_s_d_r;
    assign sck_rise_s  = sck_s & ~sck_s_d_r;

    // A clock rise clears the count; a strobe in the same cycle counts after it.
    always_comb begin
        if (sck_rise_s) begin
            strobe_cnt_nxt = strb_rise_s ? 3'h1 : 3'h0;
        end else if (strb_rise_s && (strobe_cnt_r < sadc_pkg::STROBE_SLEEP)) begin
            strobe_cnt_nxt = strobe_cnt_r + 3'h1;
        end else begin
            strobe_cnt_nxt = strobe_cnt_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            strobe_cnt_r <= 3'h0;
        end else begin
            strobe_cnt_r <= strobe_cnt_nxt;
        end
    end

    // Power state follows the strobe count; any clock rise returns to active.
    always_comb begin
        pmode_nxt = pmode_r;
        unique case (pmode_r)
            sadc_pkg::SADC_ACTIVE: begin
                if (strobe_cnt_nxt >= sadc_pkg::STROBE_SLEEP) begin
                    pmode_nxt = sadc_pkg::SADC_SLEEP;
                end else if (strobe_cnt_nxt >= sadc_pkg::STROBE_NAP) begin
                    pmode_nxt = sadc_pkg::SADC_NAP;
                end
            end
            sadc_pkg::SADC_NAP: begin
                if (sck_rise_s) begin
                    pmode_nxt = sadc_pkg::SADC_ACTIVE;
                end else if (strobe_cnt_nxt >= sadc_pkg::STROBE_SLEEP) begin
                    pmode_nxt = sadc_pkg::SADC_SLEEP;
                end
            end
            sadc_pkg::SADC_SLEEP: begin
                if (sck_rise_s) begin
                    pmode_nxt = sadc_pkg::SADC_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pmode_r <= sadc_pkg::SADC_ACTIVE;
        end else begin
            pmode_r <= pmode_nxt;
        end
    end

    // Reference settling timer, started on every wake from sleep.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settle_cnt_r <= '0;
        end else if (pmode_r == sadc_pkg::SADC_SLEEP && pmode_nxt != sadc_pkg::SADC_SLEEP) begin
            settle_cnt_r <= SW'(SETTLE_CYCLES);
        end else if (settle_cnt_r != '0) begin
            settle_cnt_r <= settle_cnt_r - SW'(1);
        end
    end

    // Status flags; the reference is only dropped in sleep.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nap_r     <= 1'b0;
            sleep_r   <= 1'b0;
            ref_pwr_r <= 1'b1;
            settled_r <= 1'b1;
        end else begin
            nap_r     <= (pmode_nxt == sadc_pkg::SADC_NAP);
            sleep_r   <= (pmode_nxt == sadc_pkg::SADC_SLEEP);
            ref_pwr_r <= (pmode_nxt != sadc_pkg::SADC_SLEEP);
            if (pmode_nxt == sadc_pkg::SADC_SLEEP || pmode_r == sadc_pkg::SADC_SLEEP) begin
                settled_r <= 1'b0;
            end else if (settle_cnt_r <= SW'(1)) begin
                settled_r <= 1'b1;
            end
        end
    end

    assign nap_mode    = nap_r;
    assign sleep_mode  = sleep_r;
    assign ref_powered = ref_pwr_r;
    assign ref_settled = settled_r;

    // ========================================================================
    // Assertions
    // ========================================================================
    logic [4:0] oe_run_r;

    // Counts how long the output has driven, to bound the burst length.
    always_ff @(posedge serial_clk or posedge rst) begin
        if (rst) begin
            oe_run_r <= 5'h00;
        end else if (oe_r) begin
            oe_run_r <= oe_run_r + 5'h01;
        end else begin
            oe_run_r <= 5'h00;
        end
    end

    a_start_prev_word: assert property (@(posedge serial_clk) disable iff (rst)
        start_w |=> oe_r && (out_r == $past(pend_r[RES-1])) && (pend_r == $past(code_w)))
        else $error("frame start did not send the previous word");

    a_burst_length: assert property (@(posedge serial_clk) disable iff (rst)
        $fell(oe_r) |-> (oe_run_r == 5'(RES)))
        else $error("result burst has the wrong number of bits");

    a_strobe_locked: assert property (@(posedge serial_clk) disable iff (rst)
        (strb_rise_l && seq_r < SEQ_OPEN) |=> (seq_r == $past(seq_r) + 5'h01))
        else $error("strobe restarted a running frame");

    a_idle_hiz: assert property (@(posedge serial_clk) disable iff (rst)
        (seq_r >= SEQ_LAST && !start_w) |=> !oe_r)
        else $error("result output driven outside its bits");
    a_code_clamp: assert property (@(posedge serial_clk) disable iff (rst)
        (diff_l < 0 |-> code_w == '0) and (diff_l >= (1 <<< RES) |-> code_w == '1))
        else $error("out-of-span input not clamped");

    a_powerup_active: assert property (@(posedge clk)
        $fell(rst) |-> (pmode_r == sadc_pkg::SADC_ACTIVE) && !sleep_r && !nap_r)
        else $error("not active after reset");

    a_nap_entry: assert property (@(posedge clk) disable iff (rst)
        (pmode_r == sadc_pkg::SADC_ACTIVE && strobe_cnt_r == 3'h1 && strb_rise_s && !sck_rise_s)
        |=> nap_r ##0 ref_pwr_r)
        else $error("second strobe-only rise did not enter nap");

    a_sleep_entry: assert property (@(posedge clk) disable iff (rst)
        (strobe_cnt_r == 3'h3 && strb_rise_s && !sck_rise_s) |=> sleep_r && !ref_pwr_r)
        else $error("fourth strobe-only rise did not enter sleep");

    a_clock_wakes: assert property (@(posedge clk) disable iff (rst)
        ((nap_r || sleep_r) && sck_rise_s) |=> !nap_r && !sleep_r && strobe_cnt_r <= 3'h1)
        else $error("clock rise did not wake the converter");

    a_settle_start: assert property (@(posedge clk) disable iff (rst)
        $fell(sleep_r) |-> (settle_cnt_r == SW'(SETTLE_CYCLES)) && !settled_r)
        else $error("reference settling not restarted on wake");

    c_frame: cover property (@(posedge serial_clk) disable iff (rst) start_w ##1 oe_r);
    c_ignored: cover property (@(posedge serial_clk) disable iff (rst)
        strb_rise_l && seq_r < SEQ_OPEN);
    c_nap: cover property (@(posedge clk) disable iff (rst) $rose(nap_r));
    c_sleep_wake: cover property (@(posedge clk) disable iff (rst) $fell(sleep_r));

endmodule : sadc_ctrl

`default_nettype wire

// ---- hw/sadc_pkg.sv ----
// Shared constants and types for the serial sampling converter control block.
package sadc_pkg;

    // ========================================================================
    // Resolution and sequencing
    // ========================================================================
    localparam int         RES_WIDE    = 14;     // Wide variant, 16384 steps.
    localparam int         RES_NARROW  = 12;     // Narrow variant, 4096 steps.
    localparam int         SEQ_W       = 5;
    localparam logic [4:0] SEQ_FIRST   = 5'h03;  // Serial edge that carries the first bit.
    localparam logic [4:0] SEQ_FRAME   = 5'h10;  // Serial edges a start locks out strobes.
    localparam logic [4:0] SEQ_IDLE    = 5'h1f;  // Saturated count, no frame running.

    // ========================================================================
    // Power-down strobe counts
    // ========================================================================
    localparam logic [2:0] STROBE_NAP   = 3'h2;
    localparam logic [2:0] STROBE_SLEEP = 3'h4;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int CLK_PERIOD_NS     = 10;
    localparam int REF_SETTLE_MS     = 2;
    localparam int REF_SETTLE_CYCLES = (REF_SETTLE_MS * 1000000) / CLK_PERIOD_NS;

    // Power state of the converter.
    typedef enum logic [1:0] {
        SADC_ACTIVE,
        SADC_NAP,
        SADC_SLEEP
    } sadc_pmode_e;

endpackage : sadc_pkg

// ---- hw/sadc_sync2.sv ----
// Two-stage synchroniser for levels entering a clock domain.
`timescale 1ns/1ps
`default_nettype none

module sadc_sync2 #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst,
    // Level in and synchronised level out.
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    // The first stage feeds only the second, so a metastable value never fans out.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : sadc_sync2

`default_nettype wire

// ---- hw/sadc_coder.sv ----
// Clamping natural-binary coder for the sampled input difference.
`timescale 1ns/1ps
`default_nettype none

module sadc_coder #(
    parameter int RES = 14
) (
    // Input difference in steps, and the result code.
    input  wire logic signed [RES+1:0] diff,
    output logic             [RES-1:0] code
);

    localparam logic signed [RES+1:0] FULL = $signed({2'b00, {RES{1'b1}}});

    // Out-of-span inputs pin the code at the ends instead of wrapping.
    always_comb begin
        if (diff < 0) begin
            code = '0;
        end else if (diff > FULL) begin
            code = '1;
        end else begin
            code = diff[RES-1:0];
        end
    end

endmodule : sadc_coder

`default_nettype wire

// ---- verif/sadc_host_model.sv ----
// Host-side model of the serial link: clock, strobe, sample and bit capture.
`timescale 1ns/1ps
`default_nettype none

module sadc_host_model #(
    parameter int RES = 14
) (
    // Link pins driven by the host.
    output logic                  serial_clk,
    output logic                  sample_strobe,
    output logic signed [RES+1:0] sample_diff,
    // Result pin seen by the host.
    input  wire logic             serial_result_out,
    input  wire logic             serial_result_oe
);
    // ========================================================================
    // Link timing
    // ========================================================================
    localparam int HALF_NS = 80;

    // The serial clock rests low between frames; it never runs free.
    initial begin
        serial_clk    = 1'b0;
        sample_strobe = 1'b0;
        sample_diff   = '0;
    end

    // A new difference is set while the clock is still, so it is steady
    // through the whole frame that samples it.
    task automatic set_diff(input logic signed [RES+1:0] d);
        sample_diff = d;
    endtask : set_diff

    // One frame: a strobe one clock period wide, then nclk clock rises.
    // Bits are taken on falling edges, half a period after they change.
    // A strobe can be re-raised after rise extra_at+1 to test the lock-out.
    task automatic frame(input int nclk, input int extra_at,
                         output logic [RES-1:0] word, output logic [17:0] oe_seen);
        begin
            word          = '0;
            oe_seen       = '0;
            #3.7;
            sample_strobe = 1'b1;
            #HALF_NS;
            for (int k = 0; k < nclk; k++) begin
                serial_clk = 1'b1;
                #HALF_NS;
                oe_seen[k] = serial_result_oe;
                if (serial_result_oe === 1'b1) begin
                    word = {word[RES-2:0], serial_result_out};
                end
                serial_clk    = 1'b0;
                sample_strobe = (k == extra_at);
                #HALF_NS;
            end
        end
    endtask : frame

    // Strobe pulses with the serial clock held still.
    task automatic strobes_only(input int n);
        for (int i = 0; i < n; i++) begin
            sample_strobe = 1'b1;
            #(2 * HALF_NS);
            sample_strobe = 1'b0;
            #(2 * HALF_NS);
        end
    endtask : strobes_only

    // A single clock rise with the strobe low.
    task automatic clock_pulse();
        begin
            serial_clk = 1'b1;
            #HALF_NS;
            serial_clk = 1'b0;
            #HALF_NS;
        end
    endtask : clock_pulse

endmodule : sadc_host_model
`default_nettype wire

// ---- verif/tb.sv ----
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
`default_nettype none

module tb;
    // ========================================================================
    // Signals and instances
    // ========================================================================
    localparam int RES    = 14;
    localparam int SETTLE = 20;

    logic                  clk;
    logic                  rst;
    logic                  serial_clk;
    logic                  sample_strobe;
    logic                  serial_result_out;
    logic                  serial_result_oe;
    logic signed [RES+1:0] sample_diff;
    logic                  nap_mode;
    logic                  sleep_mode;
    logic                  ref_powered;
    logic                  ref_settled;
    logic [3:0]            power_st;
    logic [RES-1:0]        prev_code;
    int                    num_errors;
    int                    check_count;

    // Differences over the span and past both ends.
    logic signed [RES+1:0] dv [8] = '{16'sh0000, 16'sh0001, 16'sh3fff, 16'sh4000,
                                      16'shffff, 16'sh3039, 16'sh7fff, 16'sh8000};

    // Power status packed as nap, sleep, reference powered, reference settled.
    assign power_st = {nap_mode, sleep_mode, ref_powered, ref_settled};

    // System clock, 100 MHz.
    always #5 clk = ~clk;

    sadc_ctrl #(.RES(RES), .SETTLE_CYCLES(SETTLE)) i_dut (
        .clk(clk), .rst(rst), .serial_clk(serial_clk), .sample_strobe(sample_strobe),
        .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
        .sample_diff(sample_diff), .nap_mode(nap_mode), .sleep_mode(sleep_mode),
        .ref_powered(ref_powered), .ref_settled(ref_settled));

    sadc_host_model #(.RES(RES)) i_host (
        .serial_clk(serial_clk), .sample_strobe(sample_strobe), .sample_diff(sample_diff),
        .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe));

    // ========================================================================
    // Reporting and comparison
    // ========================================================================
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic check_vec(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            num_errors++;
        end
    endtask : check_vec

    task automatic check_flag(input logic got, input logic exp);
        check_vec(32'(got), 32'(exp));
    endtask : check_flag

    // Waits a bounded number of cycles for the masked status to match.
    task automatic wait_power(input logic [3:0] exp, input logic [3:0] mask,
                              input int limit, output int cycles);
        begin
            cycles = 0;
            while ((power_st & mask) !== (exp & mask) && cycles < limit) begin
                @(negedge clk);
                cycles++;
            end
            check_vec(32'(power_st & mask), 32'(exp & mask));
            if ((power_st & mask) !== (exp & mask)) stop_test();
        end
    endtask : wait_power

    // Clamped natural-binary code expected for a difference in steps.
    function automatic logic [RES-1:0] clamp(input logic signed [RES+1:0] d);
        if (d < 0) return '0;
        if (d >= (1 <<< RES)) return '1;
        return d[RES-1:0];
    endfunction : clamp

    // One frame: the word must be the previous sample and the pin must be
    // driven only at rises 3 to 2+RES after the strobe.
    task automatic sample_strobe_check(input logic signed [RES+1:0] d, input int nclk,
                              input int extra_at);
        logic [RES-1:0] word;
        logic [17:0]    oe_seen;
        logic [17:0]    oe_exp;
        begin
            oe_exp = '0;
            for (int k = 0; k < nclk; k++) oe_exp[k] = (k >= 2 && k < 2 + RES);
            i_host.set_diff(d);
            i_host.frame(nclk, extra_at, word, oe_seen);
            check_vec(32'(word), 32'(prev_code));
            check_vec(32'(oe_seen), 32'(oe_exp));
            prev_code = clamp(d);
        end
    endtask : sample_strobe_check

    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_reset();
        int cyc;
        begin
            wait_power(4'h3, 4'hf, 0, cyc);
            check_flag(serial_result_oe, 1'b0);
        end
    endtask : t_reset

    // Back-to-back frames of 16 and 18 rises; stray strobes after 7 and after 14 rises.
    task automatic t_conversions();
        for (int i = 0; i < 8; i++) begin
            sample_strobe_check(dv[i], (i % 2 == 0) ? 16 : 18, (i == 3) ? 6 : (i == 5) ? 13 : -1);
        end
    endtask : t_conversions

    task automatic t_nap();
        int cyc;
        begin
            i_host.strobes_only(2);
            wait_power(4'hb, 4'hf, 40, cyc);
            i_host.clock_pulse();
            wait_power(4'h3, 4'hf, 40, cyc);
            sample_strobe_check(16'sh1234, 18, -1);
        end
    endtask : t_nap

    // A clock rise between two strobes must clear the count.
    task automatic t_count_clear();
        begin
            i_host.strobes_only(1);
            i_host.clock_pulse();
            i_host.strobes_only(1);
            repeat (30) @(negedge clk);
            check_vec(32'(power_st), 32'h3);
            i_host.clock_pulse();
        end
    endtask : t_count_clear

    task automatic t_sleep();
        int cyc;
        begin
            i_host.strobes_only(4);
            wait_power(4'h4, 4'h7, 40, cyc);
            i_host.strobes_only(1);
            repeat (30) @(negedge clk);
            check_vec(32'(power_st & 4'h7), 32'h4);
            // The pulse runs alongside, so settling is timed from the wake itself.
            fork
                i_host.clock_pulse();
            join_none
            wait_power(4'h2, 4'hf, 40, cyc);
            wait_power(4'h3, 4'hf, 3 * SETTLE, cyc);
            check_flag(cyc >= SETTLE - 6 && cyc <= SETTLE + 6, 1'b1);
            sample_strobe_check(16'sh2aaa, 18, -1);
        end
    endtask : t_sleep

    // Main sequence; reset is released on a falling edge.
    initial begin
        clk         = 1'b0;
        rst         = 1'b1;
        num_errors  = 0;
        check_count = 0;
        prev_code   = '0;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        t_reset();
        t_conversions();
        t_nap();
        t_count_clear();
        t_sleep();
        stop_test();
    end

endmodule : tb
`default_nettype wire
